// file: core/dma_channel_register_map_consts.vh
// Constants of the four-channel DMA register map and its channel engine.
// Assumes a word-addressed APB view: byte address = 4 * register index.
`ifndef DMA_CHANNEL_REGISTER_MAP_CONSTS_VH
`define DMA_CHANNEL_REGISTER_MAP_CONSTS_VH

// Register indices (byte address is four times the index)
`define SRC0_IDX      28'h5FFFF40
`define DST0_IDX      28'h5FFFF44
`define CNT0_IDX      28'h5FFFF4A
`define CTL0_IDX      28'h5FFFF4E
`define SRC1_IDX      28'h5FFFF50
`define DST1_IDX      28'h5FFFF54
`define CNT1_IDX      28'h5FFFF5A
`define CTL1_IDX      28'h5FFFF5E
`define SRC2_IDX      28'h5FFFF60
`define DST2_IDX      28'h5FFFF64
`define CNT2_IDX      28'h5FFFF6A
`define CTL2_IDX      28'h5FFFF6E
`define SRC3_IDX      28'h5FFFF70
`define DST3_IDX      28'h5FFFF74
`define CNT3_IDX      28'h5FFFF7A
`define CTL3_IDX      28'h5FFFF7E
`define OPER_IDX      28'h5FFFF48
// Interrupt status (read clears) and mask
`define IRQ_STAT_IDX  28'h5FFFF80
`define IRQ_MASK_IDX  28'h5FFFF84

// Reset values
`define CTL_RST       16'h0000
`define OPER_RST      16'h0000
`define ADDR_RST      32'h00000000
`define CNT_RST       16'h0000
`define IRQ_RST       6'h00

// Channel control fields
`define CC_DE         0
`define CC_TE         1
`define CC_IE         2
`define CC_TS         3
`define CC_RS_LO      8
`define CC_SM_LO      12
`define CC_DM_LO      14
// Bits 7..5 writable on channels 0 and 1 only
`define CC_WR_LIMIT   16'hFF1F

// Shared operation fields
`define OP_DME        0
`define OP_NMIF       1
`define OP_AE         2

// Request source codes
`define RS_EXT_DUAL   4'h0
`define RS_EXT_TOMEM  4'h2
`define RS_EXT_FRMEM  4'h3
`define RS_AUTO       4'hC

// Interrupt status layout
`define IS_AE         4
`define IS_NMI        5

// Idle cycles after each transfer, lets a released request settle
`define GAP_CYCLES    3'h3

`endif

// file: core/dma_channel_register_map.v
// Four-channel DMA register map with a simple channel engine and APB slave.
// Assumes APB with pstrb, one clock, external request pins asynchronous.
//
// Summary of operation
// R1: Only channels 0 and 1 take an external request pin from the peripheral.
// R2: Channels 0 and 1 drive an acknowledge pin answering their request pin.
// R3: Seventeen registers: four per channel plus one shared operation register.
// R4: Channel control bit 1 is a flag cleared by writing zero only.
// R5: Operation register bits 1 and 2 are flags cleared by writing zero only.
// R6: Software uses word or longword access for address and count registers.
// R7: Byte reads of address and count registers give undefined data.
// R8: Decode index bits 27-24 and 8-0 only; bits 23-9 are ignored.
// R9: Source address is 32-bit read/write and shows the next source address.
// R10: Destination address is 32-bit read/write, shows next destination.
// R11: Single address, peripheral to memory: source address register ignored.
// R12: Single address, memory to peripheral: destination register ignored.
// R13: Address registers carry no meaningful value until software loads them.
// R14: Count register: zero means 65536 transfers, shows remaining count.
// R15: Control and operation registers take byte, word and longword writes.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "dma_channel_register_map_consts.vh"

module dma_channel_register_map
(
  // Clock and reset
  input  wire        clk_sys_in,
  input  wire        arst_n_in,
  // APB slave
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [31:0] paddr_in,
  input  wire [31:0] pwdata_in,
  input  wire [3:0]  pstrb_in,
  output reg  [31:0] prdata_out,
  output reg         pready_out,
  output reg         pslverr_out,
  // External peripheral handshake
  input  wire        ext_request_ch0_in,
  input  wire        ext_request_ch1_in,
  output reg         ext_acknowledge_ch0_out,
  output reg         ext_acknowledge_ch1_out,
  // Non-maskable interrupt pin, stops all channels
  input  wire        nmi_in,
  // Interrupt
  output reg         irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  localparam ST_IDLE = 2'h0;
  localparam ST_ACK  = 2'h1;
  localparam ST_GAP  = 2'h2;

  wire [27:0] idx = paddr_in[29:2];
  // Completing edge: the one where the master samples pready high
  wire        done_acc = psel_in & penable_in & pready_out;
  wire        wr_acc   = done_acc & pwrite_in;

  // Only the decoded bits take part in the match
  function hit;
    input [27:0] a;
    input [27:0] c;
    begin
      hit = (a[27:24] == c[27:24]) && (a[8:0] == c[8:0]); // [R8]
    end
  endfunction

  // Byte-lane merge of write data into a register
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  st;
    integer      b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1)
        if (st[b])
          merge[b*8 +: 8] = wd[b*8 +: 8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Shared state

  reg  [15:0]  oper_q;
  reg  [5:0]   stat_q;
  reg  [5:0]   mask_q;
  reg  [5:0]   rd_snap_q;
  reg  [1:0]   state_q;
  reg  [1:0]   cur_q;
  reg  [2:0]   gap_q;
  reg  [1:0]   req_s1_q;
  reg  [1:0]   req_s2_q;
  reg          nmi_s1_q;
  reg          nmi_s2_q;
  reg          nmi_s3_q;

  wire [127:0] src_all;
  wire [127:0] dst_all;
  wire [63:0]  cnt_all;
  wire [63:0]  ctl_all;
  wire [3:0]   ready;
  wire [3:0]   bad_mode;
  wire [3:0]   te_set;
  wire [3:0]   is_ext;
  wire [3:0]   dreq = {2'b00, req_s2_q};  // [R1]

  wire sel_oper = hit(idx, `OPER_IDX);
  wire sel_stat = hit(idx, `IRQ_STAT_IDX);
  wire sel_mask = hit(idx, `IRQ_MASK_IDX);
  wire run_ok   = oper_q[`OP_DME] & ~oper_q[`OP_NMIF] & ~oper_q[`OP_AE];
  wire nmi_rise = nmi_s2_q & ~nmi_s3_q;

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel registers

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1)
    begin : g_ch
      localparam [27:0] SRC_I  = (ch == 0) ? `SRC0_IDX :
                                 (ch == 1) ? `SRC1_IDX :
                                 (ch == 2) ? `SRC2_IDX : `SRC3_IDX;
      localparam [27:0] DST_I  = (ch == 0) ? `DST0_IDX :
                                 (ch == 1) ? `DST1_IDX :
                                 (ch == 2) ? `DST2_IDX : `DST3_IDX;
      localparam [27:0] CNT_I  = (ch == 0) ? `CNT0_IDX :
                                 (ch == 1) ? `CNT1_IDX :
                                 (ch == 2) ? `CNT2_IDX : `CNT3_IDX;
      localparam [27:0] CTL_I  = (ch == 0) ? `CTL0_IDX :
                                 (ch == 1) ? `CTL1_IDX :
                                 (ch == 2) ? `CTL2_IDX : `CTL3_IDX;
      localparam [15:0] WMASK  = (ch < 2) ? 16'hFFFF : `CC_WR_LIMIT;

      reg  [31:0] src_q;
      reg  [31:0] dst_q;
      reg  [15:0] cnt_q;
      reg  [15:0] ctl_q;

      wire [3:0]  rs   = ctl_q[`CC_RS_LO +: 4];
      wire [1:0]  sm   = ctl_q[`CC_SM_LO +: 2];
      wire [1:0]  dm   = ctl_q[`CC_DM_LO +: 2];
      wire [31:0] step = ctl_q[`CC_TS] ? 32'h00000002 : 32'h00000001;
      wire        ext  = (rs == `RS_EXT_DUAL) || (rs == `RS_EXT_TOMEM) ||
                         (rs == `RS_EXT_FRMEM);
      // Illegal increment codes raise an address error instead of a move
      wire        bad  = (sm == 2'h3) || (dm == 2'h3);
      wire        req  = (ext && dreq[ch]) || (rs == `RS_AUTO);
      wire        xfer = (state_q == ST_ACK) && (cur_q == ch);
      wire        last = xfer && (cnt_q == 16'h0001);
      wire [31:0] cc_m = merge({16'h0000, ctl_q}, pwdata_in, pstrb_in);
      wire [31:0] tc_m = merge({16'h0000, cnt_q}, pwdata_in, pstrb_in);
      wire [15:0] cc_w = cc_m[15:0] & WMASK;

      assign is_ext[ch]   = ext && (ch < 2);
      assign ready[ch]    = run_ok & ctl_q[`CC_DE] & ~ctl_q[`CC_TE] &
                            req & ~bad;
      assign bad_mode[ch] = run_ok & ctl_q[`CC_DE] & ~ctl_q[`CC_TE] &
                            req & bad;
      assign te_set[ch]   = last;
      assign src_all[ch*32 +: 32] = src_q;
      assign dst_all[ch*32 +: 32] = dst_q;
      assign cnt_all[ch*16 +: 16] = cnt_q;
      assign ctl_all[ch*16 +: 16] = ctl_q;

      // Software write wins over the engine's address and count update
      always @(posedge clk_sys_in or negedge arst_n_in)
      begin
        if (!arst_n_in)
        begin
          src_q <= `ADDR_RST;                            // [R13]
          dst_q <= `ADDR_RST;                            // [R13]
          cnt_q <= `CNT_RST;
          ctl_q <= `CTL_RST;
        end
        else
        begin
          if (wr_acc && hit(idx, SRC_I))
            src_q <= merge(src_q, pwdata_in, pstrb_in);  // [R9]
          else if (xfer && rs != `RS_EXT_TOMEM && sm == 2'h1)
            src_q <= src_q + step;                       // [R9] [R11]
          else if (xfer && rs != `RS_EXT_TOMEM && sm == 2'h2)
            src_q <= src_q - step;                       // [R9] [R11]
          if (wr_acc && hit(idx, DST_I))
            dst_q <= merge(dst_q, pwdata_in, pstrb_in);  // [R10]
          else if (xfer && rs != `RS_EXT_FRMEM && dm == 2'h1)
            dst_q <= dst_q + step;                       // [R10] [R12]
          else if (xfer && rs != `RS_EXT_FRMEM && dm == 2'h2)
            dst_q <= dst_q - step;                       // [R10] [R12]
          // Byte writes store the lane given; contents then undefined
          if (wr_acc && hit(idx, CNT_I))
            cnt_q <= tc_m[15:0];                         // [R6]
          else if (xfer)
            cnt_q <= cnt_q - 16'h0001;                   // [R14]
          if (wr_acc && hit(idx, CTL_I))
          begin
            ctl_q <= cc_w;                               // [R15]
            // Zero clears the flag, one keeps it; a new set still wins
            ctl_q[`CC_TE] <= last |
                             (ctl_q[`CC_TE] & cc_w[`CC_TE]); // [R4]
          end
          else if (last)
            ctl_q[`CC_TE] <= 1'b1;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  always @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      req_s1_q <= 2'h0;
      req_s2_q <= 2'h0;
      nmi_s1_q <= 1'b0;
      nmi_s2_q <= 1'b0;
      nmi_s3_q <= 1'b0;
    end
    else
    begin
      req_s1_q <= {ext_request_ch1_in, ext_request_ch0_in}; // [R1]
      req_s2_q <= req_s1_q;
      nmi_s1_q <= nmi_in;
      nmi_s2_q <= nmi_s1_q;
      nmi_s3_q <= nmi_s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer engine: fixed priority, channel 0 highest

  reg [1:0] pick;
  always @*
  begin
    pick = 2'h0;
    if (ready[3]) pick = 2'h3;
    if (ready[2]) pick = 2'h2;
    if (ready[1]) pick = 2'h1;
    if (ready[0]) pick = 2'h0;
  end

  // One transfer per pass; the gap lets the peripheral drop its request
  always @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_q                 <= ST_IDLE;
      cur_q                   <= 2'h0;
      gap_q                   <= 3'h0;
      ext_acknowledge_ch0_out <= 1'b0;
      ext_acknowledge_ch1_out <= 1'b0;
    end
    else
    begin
      ext_acknowledge_ch0_out <= 1'b0;
      ext_acknowledge_ch1_out <= 1'b0;
      case (state_q)
        ST_IDLE:
          if (|ready)
          begin
            state_q                 <= ST_ACK;
            cur_q                   <= pick;
            ext_acknowledge_ch0_out <= (pick == 2'h0) & is_ext[0]; // [R2]
            ext_acknowledge_ch1_out <= (pick == 2'h1) & is_ext[1]; // [R2]
          end
        ST_ACK:
        begin
          state_q <= ST_GAP;
          gap_q   <= `GAP_CYCLES;
        end
        ST_GAP:
        begin
          gap_q <= gap_q - 3'h1;
          if (gap_q == 3'h1)
            state_q <= ST_IDLE;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared operation, interrupt status and mask

  wire [31:0] op_m = merge({16'h0000, oper_q}, pwdata_in, pstrb_in);
  wire [15:0] op_w = op_m[15:0];
  wire [5:0]  ev   = {nmi_rise, |bad_mode, te_set &
                      {ctl_all[48 + `CC_IE], ctl_all[32 + `CC_IE],
                       ctl_all[16 + `CC_IE], ctl_all[`CC_IE]}};
  // Only bits seen by the completing read are cleared, new events stay
  wire [5:0]  stat_d = (stat_q & ~((done_acc & ~pwrite_in & sel_stat) ?
                       rd_snap_q : 6'h00)) | ev;

  always @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      oper_q  <= `OPER_RST;
      stat_q  <= `IRQ_RST;
      mask_q  <= `IRQ_RST;
      irq_out <= 1'b0;
    end
    else
    begin
      if (wr_acc && sel_oper)
      begin
        oper_q            <= op_w;                       // [R15]
        oper_q[`OP_NMIF]  <= nmi_rise |
                             (oper_q[`OP_NMIF] & op_w[`OP_NMIF]); // [R5]
        oper_q[`OP_AE]    <= (|bad_mode) |
                             (oper_q[`OP_AE] & op_w[`OP_AE]);     // [R5]
      end
      else
      begin
        if (nmi_rise)
          oper_q[`OP_NMIF] <= 1'b1;
        if (|bad_mode)
          oper_q[`OP_AE] <= 1'b1;
      end
      if (wr_acc && sel_mask)
        mask_q <= pwdata_in[5:0];
      stat_q  <= stat_d;
      irq_out <= |(stat_d & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read mux and one-wait-state answer

  reg [31:0] rd_d;
  reg        map_d;
  reg [27:0] base;
  integer    k;
  always @*
  begin
    rd_d  = 32'h00000000;
    base  = 28'h0000000;
    map_d = sel_oper | sel_stat | sel_mask;
    if (sel_oper) rd_d = {16'h0000, oper_q};
    if (sel_stat) rd_d = {26'h0000000, stat_q};
    if (sel_mask) rd_d = {26'h0000000, mask_q};
    // Seventeen mapped registers plus interrupt pair
    for (k = 0; k < 4; k = k + 1)
    begin
      base = `SRC0_IDX + {22'h000000, k[1:0], 4'h0};
      if (hit(idx, base))
      begin
        rd_d  = src_all[k*32 +: 32];                     // [R3] [R9]
        map_d = 1'b1;
      end
      if (hit(idx, base + 28'h0000004))
      begin
        rd_d  = dst_all[k*32 +: 32];                     // [R10]
        map_d = 1'b1;
      end
      if (hit(idx, base + 28'h000000A))
      begin
        rd_d  = {16'h0000, cnt_all[k*16 +: 16]};         // [R14] [R7]
        map_d = 1'b1;
      end
      if (hit(idx, base + 28'h000000E))
      begin
        rd_d  = {16'h0000, ctl_all[k*16 +: 16]};
        map_d = 1'b1;
      end
    end
  end

  always @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h00000000;
      rd_snap_q   <= 6'h00;
    end
    else
    begin
      pready_out  <= psel_in & penable_in & ~pready_out;
      pslverr_out <= psel_in & penable_in & ~pready_out & ~map_d;
      if (psel_in & penable_in & ~pready_out)
      begin
        prdata_out <= pwrite_in ? 32'h00000000 : rd_d;
        rd_snap_q  <= stat_q;
      end
    end
  end

endmodule // dma_channel_register_map

// file: bench/dma_channel_register_map_sva.sv
// Checker for the DMA register map: APB timing, decode, acknowledge pins.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ps
module dma_map_checker
(
  // Clock and reset
  input wire        clk_sys_in,
  input wire        arst_n_in,
  // APB
  input wire        psel_in,
  input wire        penable_in,
  input wire        pwrite_in,
  input wire [31:0] paddr_in,
  input wire [31:0] prdata_out,
  input wire        pready_out,
  input wire        pslverr_out,
  // Peripheral pins and interrupt
  input wire        ext_request_ch0_in,
  input wire        ext_request_ch1_in,
  input wire        ext_acknowledge_ch0_out,
  input wire        ext_acknowledge_ch1_out,
  input wire        irq_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  ////////////////////////////////////////////////////////////////////////////
  // Only index bits 27-24 and 8-0 pick a register
  function automatic logic mapped(input logic [31:0] a);
    logic [8:0] l;
    l = a[10:2];
    mapped = (a[29:26] == 4'h5) && (l == 9'h148 || l == 9'h180 ||
      l == 9'h184 || (l[8:6] == 3'h5 && (l[3:0] == 4'h0 ||
      l[3:0] == 4'h4 || l[3:0] == 4'hA || l[3:0] == 4'hE)));
  endfunction
  // Steps of an APB access and of the transfer spacing
  sequence s_first_access;
    psel_in && penable_in && !pready_out;
  endsequence
  sequence s_ack_quiet;
    !(ext_acknowledge_ch0_out || ext_acknowledge_ch1_out) [*4];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_one_wait_state: assert property (s_first_access |=> pready_out)
    else $error("ready not one cycle after access start");
  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready held longer than one cycle");
  a_ready_in_access: assert property
    (pready_out |-> psel_in && penable_in)
    else $error("ready outside an access");
  a_decode_error: assert property
    (pready_out |-> pslverr_out == !mapped(paddr_in))
    else $error("error response disagrees with decode");
  a_write_rdata_zero: assert property
    (pready_out && pwrite_in |-> prdata_out == 32'h0)
    else $error("read data not zero on write");
  a_ack_gap: assert property
    (ext_acknowledge_ch0_out || ext_acknowledge_ch1_out |=> s_ack_quiet)
    else $error("acknowledge pulses too close");
  a_ack0_cause: assert property (ext_acknowledge_ch0_out |->
    $past(ext_request_ch0_in, 2) || $past(ext_request_ch0_in, 3) ||
    $past(ext_request_ch0_in, 4) || $past(ext_request_ch0_in, 5))
    else $error("channel 0 acknowledge without request");
  a_ack1_cause: assert property (ext_acknowledge_ch1_out |->
    $past(ext_request_ch1_in, 2) || $past(ext_request_ch1_in, 3) ||
    $past(ext_request_ch1_in, 4) || $past(ext_request_ch1_in, 5))
    else $error("channel 1 acknowledge without request");
  a_quiet_after_reset: assert property ($rose(arst_n_in) |->
    !pready_out && !ext_acknowledge_ch0_out && !ext_acknowledge_ch1_out
    && !irq_out)
    else $error("outputs active right after reset");
endmodule // dma_map_checker

bind dma_channel_register_map dma_map_checker u_dma_map_checker
(
  .clk_sys_in, .arst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
  .prdata_out, .pready_out, .pslverr_out, .ext_request_ch0_in,
  .ext_request_ch1_in, .ext_acknowledge_ch0_out, .ext_acknowledge_ch1_out,
  .irq_out
);

// file: bench/ext_peripheral_model.sv
// Model of an external peripheral on one request/acknowledge pair.
// Assumes a level request and a one-cycle acknowledge pulse.
`timescale 1ns/1ps
module ext_peripheral_model
(
  // Clock and reset
  input  wire clk_sys_in,
  input  wire arst_n_in,
  // Bench control and pins
  input  wire want_in,
  input  wire ack_in,
  output reg  req_out
);
  reg [2:0] hold_q;
  ////////////////////////////////////////////////////////////////////////////
  // Drop on acknowledge, then rest so a stale level is never re-served
  always @(posedge clk_sys_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      req_out <= 1'b0;
      hold_q  <= 3'h0;
    end
    else if (ack_in)
    begin
      req_out <= 1'b0; // Released next cycle
      hold_q  <= 3'h5;
    end
    else if (hold_q != 3'h0)
      hold_q <= hold_q - 3'h1;
    else
      req_out <= want_in; // Own pin only
endmodule // ext_peripheral_model

// file: bench/dma_channel_register_map_tb_top.sv
// Self-checking bench for the DMA register map.
// Assumes the constants header and an APB slave answering with pready.
`timescale 1ns/1ps
`include "dma_channel_register_map_consts.vh"
module dma_channel_register_map_tb_top;
  typedef struct packed
  {
    logic [27:0] wi;
    logic [27:0] ri;
    logic [31:0] d;
    logic [3:0]  s;
    logic [31:0] e;
  } row_t;
  reg         clk_sys_in = 1'b0;
  reg         arst_n_in  = 1'b0;
  reg         psel_in    = 1'b0;
  reg         penable_in = 1'b0;
  reg         pwrite_in  = 1'b0;
  reg  [31:0] paddr_in   = 32'h0;
  reg  [31:0] pwdata_in  = 32'h0;
  reg  [3:0]  pstrb_in   = 4'h0;
  reg  [1:0]  want       = 2'h0;
  wire [31:0] prdata_out;
  wire        pready_out, pslverr_out, irq_out, req0, req1, ack0, ack1;
  integer     n_mismatch = 0;
  integer     num_checks = 0;
  integer     cycles     = 0;
  integer     acks [0:1];
  integer     i;
  reg  [31:0] rdat;
  reg         rerr;
  row_t       rows [0:8];
  ////////////////////////////////////////////////////////////////////////////
  dma_channel_register_map u_dma_channel_register_map
  (
    .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .ext_request_ch0_in(req0), .ext_request_ch1_in(req1),
    .ext_acknowledge_ch0_out(ack0), .ext_acknowledge_ch1_out(ack1),
    .nmi_in(1'b0), .irq_out(irq_out)
  );
  ext_peripheral_model u_ext_peripheral_model_0
  (
    .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .want_in(want[0]),
    .ack_in(ack0), .req_out(req0)
  );
  ext_peripheral_model u_ext_peripheral_model_1
  (
    .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .want_in(want[1]),
    .ack_in(ack1), .req_out(req1)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Clock, acknowledge counting and the hang limit
  initial
    forever #50 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in)
  begin
    if (ack0) acks[0] = acks[0] + 1;
    if (ack1) acks[1] = acks[1] + 1;
    cycles = cycles + 1;
    if (cycles == 5000)
    begin
      n_mismatch = n_mismatch + 1;
      final_report;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, got);
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Setup, access, hold until pready is seen at an edge
  task automatic apb(input logic w, input logic [27:0] ix,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= {2'b00, ix, 2'b00};
    pwdata_in <= d;
    pstrb_in <= s;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    @(posedge clk_sys_in);
    while (pready_out !== 1'b1)
      @(posedge clk_sys_in);
    rdat = prdata_out;
    rerr = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic wr(input logic [27:0] ix, input logic [31:0] d);
    apb(1'b1, ix, d, 4'hF);
  endtask
  task automatic rd(input logic [27:0] ix);
    apb(1'b0, ix, 32'h0, 4'h0);
  endtask
  // One channel run from 0x100 to 0x200, byte steps, interrupt on end
  task automatic xfer(input integer ch, input logic [3:0] rs,
                      input logic [15:0] n, input logic [31:0] es, ed);
    logic [27:0] b;
    integer k;
    b = ch ? `SRC1_IDX : `SRC0_IDX;
    acks[ch] = 0;
    k = 0;
    wr(b, 32'h100);
    wr(b + 28'h4, 32'h200);
    wr(b + 28'hA, {16'h0, n});
    wr(b + 28'hE, {16'h0, 4'h5, rs, 8'h05});
    want[ch] <= 1'b1;
    rd(b + 28'hE);
    while (rdat[1] !== 1'b1 && k < 40)
    begin
      rd(b + 28'hE);
      k = k + 1;
    end
    want[ch] <= 1'b0;
    chk("end flag", {16'h0, 4'h5, rs, 8'h07}, rdat);
    rd(b);
    chk("source", es, rdat);
    rd(b + 28'h4);
    chk("destination", ed, rdat);
    rd(b + 28'hA);
    chk("count left", 32'h0, rdat);
    chk("acknowledges", n, acks[ch]);
    chk("irq set", 32'h1, irq_out);
    rd(`IRQ_STAT_IDX);
    chk("status", 32'h1 << ch, rdat);
    rd(`IRQ_STAT_IDX);
    chk("status cleared", 32'h0, rdat);
    chk("irq clear", 32'h0, irq_out);
    wr(b + 28'hE, 32'h00000006);
    rd(b + 28'hE);
    chk("flag kept", 32'h00000006, rdat);
    wr(b + 28'hE, 32'h0);
    rd(b + 28'hE);
    chk("flag cleared", 32'h0, rdat);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, table rows, decode misses, transfers
  initial
  begin
    rows = '{
      '{`SRC0_IDX, `SRC0_IDX, 32'h12345678, 4'hF, 32'h12345678},
      '{`DST3_IDX, `DST3_IDX, 32'hA5A5F00F, 4'hF, 32'hA5A5F00F},
      '{`CNT1_IDX, `CNT1_IDX, 32'hFFFFBEEF, 4'hF, 32'h0000BEEF},
      '{`CTL2_IDX, `CTL2_IDX, 32'h000050FE, 4'hF, 32'h0000501C},
      '{`CTL0_IDX, `CTL0_IDX, 32'h000000E2, 4'hF, 32'h000000E0},
      '{`CTL3_IDX, `CTL3_IDX, 32'h0000FF1C, 4'h1, 32'h0000001C},
      '{`SRC1_IDX | 28'h0001000, `SRC1_IDX, 32'hCAFE0001, 4'hF,
        32'hCAFE0001},
      '{`OPER_IDX, `OPER_IDX, 32'h00000006, 4'hF, 32'h0},
      '{`IRQ_MASK_IDX, `IRQ_MASK_IDX, 32'h3, 4'hF, 32'h3}};
    repeat (4) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    for (i = 0; i < 4; i = i + 1)
    begin
      rd(`CTL0_IDX + 28'h10 * i);
      chk("control reset", 32'h0, rdat);
    end
    rd(`OPER_IDX);
    chk("operation reset", 32'h0, rdat);
    for (i = 0; i < 9; i = i + 1)
    begin
      apb(1'b1, rows[i].wi, rows[i].d, rows[i].s);
      rd(rows[i].ri);
      chk("register", rows[i].e, rdat);
    end
    rd(28'h5FFFF90);
    chk("unmapped error", 32'h1, rerr);
    chk("unmapped data", 32'h0, rdat);
    wr(28'h4FFFF40, 32'h0);
    chk("high bits error", 32'h1, rerr);
    rd(`SRC0_IDX);
    chk("no alias", 32'h12345678, rdat);
    wr(`OPER_IDX, 32'h1);
    xfer(0, `RS_EXT_DUAL, 16'h0002, 32'h102, 32'h202);
    xfer(1, `RS_EXT_TOMEM, 16'h0001, 32'h100, 32'h201);
    xfer(0, `RS_EXT_FRMEM, 16'h0001, 32'h101, 32'h200);
    // Illegal source mode on an auto channel raises the error flag
    wr(`CTL2_IDX, 32'h00003C01);
    rd(`OPER_IDX);
    chk("error flag set", 32'h5, rdat);
    wr(`CTL2_IDX, 32'h0);
    wr(`OPER_IDX, 32'h5);
    rd(`OPER_IDX);
    chk("error flag kept", 32'h5, rdat);
    wr(`OPER_IDX, 32'h1);
    rd(`OPER_IDX);
    chk("error flag cleared", 32'h1, rdat);
    final_report;
  end
endmodule // dma_channel_register_map_tb_top
